// [logic/pam_pkg.sv]
// package for the port A direction and upper function-select block
// assumes one system clock and an APB register bus with 32-bit data
package pam_pkg;

	localparam int PIN_COUNT = 16;

	// register byte offsets
	localparam logic [11:0] DIR_OFFSET = 12'h000;
	localparam logic [11:0] FUNC_OFFSET = 12'h004;
	localparam logic [11:0] LEVEL_OFFSET = 12'h008;

	// reset values
	localparam logic [15:0] DIR_RESET = 16'h0000;
	localparam logic [15:0] FUNC_RESET = 16'h0000;

	// writable bits of the function-select register; bits 15, 11, 7, 3 stay zero
	localparam logic [15:0] FUNC_WRITE_MASK = 16'h7777;

	// field positions of the function-select register
	localparam int FIELD_PIN15_LSB = 12;
	localparam int FIELD_PIN14_LSB = 8;
	localparam int FIELD_PIN13_LSB = 4;
	localparam int FIELD_PIN12_LSB = 0;

	// function codes
	localparam logic [2:0] FUNC_GPIO = 3'h0;
	localparam logic [2:0] FUNC_SERIAL = 3'h6;

	// direction bits that act on the reduced-pin package
	localparam logic [15:0] REDUCED_DIR_MASK = 16'h03db;
	localparam logic [15:0] FULL_DIR_MASK = 16'hffff;

	// control of one pin cell
	typedef struct packed {
		logic alt_sel;
		logic alt_out;
		logic alt_drive;
		logic gpio_out;
		logic gpio_dir;
	} pam_pin_ctl_t;

	// one APB request as seen by the slave
	typedef struct packed {
		logic sel;
		logic enable;
		logic write;
		logic [11:0] addr;
		logic [31:0] wdata;
		logic [3:0] strb;
	} pam_apb_req_t;

endpackage

// [logic/pam_pin_cell.sv]
// one port A pin: input synchroniser with agree filter and registered output driver
// assumes pin_in is asynchronous to clock; pin_oe_n low means the pin is driven
`timescale 1ns/1ps
`default_nettype none

module pam_pin_cell (
	input wire logic clock,
	input wire logic rst,
	input wire logic pin_in,
	input wire pam_pkg::pam_pin_ctl_t ctl,
	output logic pin_out,
	output logic pin_oe_n,
	output logic level
);
	import pam_pkg::*;

	logic sync1;
	logic sync2;
	logic sync3;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sync1 <= 1'b0;
			sync2 <= 1'b0;
			sync3 <= 1'b0;
		end else begin
			sync1 <= pin_in;
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	// a change counts once the second and third stage agree
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			level <= 1'b0;
		end else if (sync2 == sync3) begin
			level <= sync3;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pin_out <= 1'b0;
			pin_oe_n <= 1'b1;
		end else if (ctl.alt_sel) begin
			pin_out <= ctl.alt_out;
			pin_oe_n <= ~ctl.alt_drive;
		end else begin
			pin_out <= ctl.gpio_out;
			pin_oe_n <= ~ctl.gpio_dir;
		end
	end

endmodule

`default_nettype wire

// [logic/pam_port_a.sv]
// How it works
// - direction bit 1 drives pin, 0 inputs
// - 16-bit read/write direction register, bit per pin
// - direction ignored while pin routed elsewhere
// - reduced package ignores direction bits 15-10,5,2
// - direction register resets to all zeros
// - 16-bit read/write function-select register
// - reserved bits 15,11,7,3 read zero
// - pin 15: 000 GPIO, 110 serial1 transmit
// - pin 14: 000 GPIO, 110 serial1 receive
// - pin 13: 000 GPIO, 110 serial1 clock
// - pin 12: 000 GPIO, 110 serial0 clock
//
// port A direction and upper function-select block, APB slave
// assumes the GPIO data register and serial units sit on the same clock
//
// The address map and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module pam_port_a #(
	parameter int ADDR_W = 12,
	parameter bit REDUCED_PKG = 1'b0
) (
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [ADDR_W-1:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [3:0] PSTRB,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic [pam_pkg::PIN_COUNT-1:0] PIN_IN,
	output logic [pam_pkg::PIN_COUNT-1:0] PIN_OUT,
	output logic [pam_pkg::PIN_COUNT-1:0] PIN_OE_N,
	input wire logic [pam_pkg::PIN_COUNT-1:0] GPIO_OUT,
	output logic [pam_pkg::PIN_COUNT-1:0] GPIO_IN,
	input wire logic SER1_TX,
	output logic SER1_RX,
	input wire logic SER1_CLK_OUT,
	input wire logic SER1_CLK_DRIVE,
	output logic SER1_CLK_IN,
	input wire logic SER0_CLK_OUT,
	input wire logic SER0_CLK_DRIVE,
	output logic SER0_CLK_IN
);
	import pam_pkg::*;

	if (ADDR_W < 12 || ADDR_W > 32) begin : g_bad_addr
		$error("ADDR_W must lie between 12 and 32");
	end

	localparam logic [15:0] DIR_ACT_MASK = REDUCED_PKG ? REDUCED_DIR_MASK : FULL_DIR_MASK;

	// which register word the current address selects
	typedef enum {
		TGT_NONE,
		TGT_DIR,
		TGT_FUNC,
		TGT_LEVEL
	} pam_target_t;

	pam_target_t target;
	pam_apb_req_t req;
	logic [15:0] porta_pin_direction_reg;
	logic [15:0] porta_upper_func_reg;
	logic [PIN_COUNT-1:0] level;
	logic [PIN_COUNT-1:0] alt_sel;
	logic [PIN_COUNT-1:0] alt_out;
	logic [PIN_COUNT-1:0] alt_drive;
	logic [PIN_COUNT-1:0] dir_eff;
	logic [2:0] pin15_func_field;
	logic [2:0] pin14_func_field;
	logic [2:0] pin13_func_field;
	logic [2:0] pin12_func_field;
	logic addr_hit_dir;
	logic addr_hit_func;
	logic addr_hit_level;
	logic addr_hit;
	logic upper_zero;
	logic setup_phase;
	logic write_now;
	logic [15:0] strb_mask;
	logic [15:0] next_dir;
	logic [15:0] next_func;
	logic [31:0] next_rdata;

	// bus request gathered into one carrier; upper address bits must be zero
	always_comb begin
		req.sel = PSEL;
		req.enable = PENABLE;
		req.write = PWRITE;
		req.addr = PADDR[11:0];
		req.wdata = PWDATA;
		req.strb = PSTRB;
	end

	if (ADDR_W > 12) begin : g_upper
		assign upper_zero = (PADDR[ADDR_W-1:12] == '0);
	end else begin : g_no_upper
		assign upper_zero = 1'b1;
	end

	// address decode; anything outside the three words is unmapped
	always_comb begin
		target = TGT_NONE;
		if (upper_zero) begin
			case (req.addr)
				DIR_OFFSET: begin
					target = TGT_DIR;
				end
				FUNC_OFFSET: begin
					target = TGT_FUNC;
				end
				LEVEL_OFFSET: begin
					target = TGT_LEVEL;
				end
				default: begin
					target = TGT_NONE;
				end
			endcase
		end
	end

	assign addr_hit_dir = (target == TGT_DIR);
	assign addr_hit_func = (target == TGT_FUNC);
	assign addr_hit_level = (target == TGT_LEVEL);
	assign addr_hit = addr_hit_dir || addr_hit_func || addr_hit_level;
	assign setup_phase = req.sel && !req.enable;

	// a write takes effect on the access edge where the slave is ready
	assign write_now = req.sel && req.enable && PREADY && req.write;
	assign strb_mask = {{8{req.strb[1]}}, {8{req.strb[0]}}};

	// field views of the function-select register
	assign pin15_func_field = porta_upper_func_reg[FIELD_PIN15_LSB +: 3];
	assign pin14_func_field = porta_upper_func_reg[FIELD_PIN14_LSB +: 3];
	assign pin13_func_field = porta_upper_func_reg[FIELD_PIN13_LSB +: 3];
	assign pin12_func_field = porta_upper_func_reg[FIELD_PIN12_LSB +: 3];

	// next direction value under byte strobes
	always_comb begin
		next_dir = porta_pin_direction_reg;
		if (write_now && addr_hit_dir) begin
			next_dir = (req.wdata[15:0] & strb_mask) | (porta_pin_direction_reg & ~strb_mask);
		end
	end

	// next function-select value under byte strobes; reserved bits never stored
	always_comb begin
		next_func = porta_upper_func_reg;
		if (write_now && addr_hit_func) begin
			next_func = (req.wdata[15:0] & strb_mask) | (porta_upper_func_reg & ~strb_mask);
			next_func = next_func & FUNC_WRITE_MASK;
		end
	end

	// direction register: all pins inputs after reset
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			porta_pin_direction_reg <= DIR_RESET;
		end else begin
			porta_pin_direction_reg <= next_dir;
		end
	end

	// function-select register: every field at GPIO after reset
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			porta_upper_func_reg <= FUNC_RESET;
		end else begin
			porta_upper_func_reg <= next_func;
		end
	end

	// read data for the setup phase, answered one cycle later
	always_comb begin
		next_rdata = 32'h0000_0000;
		case (target)
			TGT_DIR: begin
				next_rdata = {16'h0000, porta_pin_direction_reg};
			end
			TGT_FUNC: begin
				next_rdata = {16'h0000, porta_upper_func_reg & FUNC_WRITE_MASK};
			end
			TGT_LEVEL: begin
				next_rdata = {16'h0000, level};
			end
			default: begin
				next_rdata = 32'h0000_0000;
			end
		endcase
	end

	// slave answers with one wait-free access phase: ready in the first access cycle
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			PREADY <= 1'b0;
		end else begin
			PREADY <= setup_phase;
		end
	end

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			PSLVERR <= 1'b0;
		end else if (setup_phase) begin
			PSLVERR <= !addr_hit || (req.write && addr_hit_level);
		end else begin
			PSLVERR <= 1'b0;
		end
	end

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			PRDATA <= 32'h0000_0000;
		end else if (setup_phase && !req.write) begin
			PRDATA <= next_rdata;
		end else if (!req.sel) begin
			PRDATA <= 32'h0000_0000;
		end
	end

	// routing of pins 15 to 12; other codes leave the pin at GPIO
	always_comb begin
		alt_sel = '0;
		alt_out = '0;
		alt_drive = '0;
		// pin 15: transmit data, always driven while routed
		case (pin15_func_field)
			FUNC_GPIO: begin
				alt_sel[15] = 1'b0;
			end
			FUNC_SERIAL: begin
				alt_sel[15] = 1'b1;
				alt_out[15] = SER1_TX;
				alt_drive[15] = 1'b1;
			end
			default: begin
				alt_sel[15] = 1'b0;
			end
		endcase

		// pin 14: receive data, never driven while routed
		case (pin14_func_field)
			FUNC_GPIO: begin
				alt_sel[14] = 1'b0;
			end
			FUNC_SERIAL: begin
				alt_sel[14] = 1'b1;
				alt_drive[14] = 1'b0;
			end
			default: begin
				alt_sel[14] = 1'b0;
			end
		endcase

		// pin 13: serial1 clock, driven only when the serial unit asks
		case (pin13_func_field)
			FUNC_GPIO: begin
				alt_sel[13] = 1'b0;
			end
			FUNC_SERIAL: begin
				alt_sel[13] = 1'b1;
				alt_out[13] = SER1_CLK_OUT;
				alt_drive[13] = SER1_CLK_DRIVE;
			end
			default: begin
				alt_sel[13] = 1'b0;
			end
		endcase

		// pin 12: serial0 clock, driven only when the serial unit asks
		case (pin12_func_field)
			FUNC_GPIO: begin
				alt_sel[12] = 1'b0;
			end
			FUNC_SERIAL: begin
				alt_sel[12] = 1'b1;
				alt_out[12] = SER0_CLK_OUT;
				alt_drive[12] = SER0_CLK_DRIVE;
			end
			default: begin
				alt_sel[12] = 1'b0;
			end
		endcase
	end

	// effective direction: masked on the reduced package and while routed away
	assign dir_eff = porta_pin_direction_reg & DIR_ACT_MASK & ~alt_sel;

	for (genvar n = 0; n < PIN_COUNT; n++) begin : g_pin
		pam_pin_ctl_t ctl;
		always_comb begin
			ctl.alt_sel = alt_sel[n];
			ctl.alt_out = alt_out[n];
			ctl.alt_drive = alt_drive[n];
			ctl.gpio_out = GPIO_OUT[n];
			ctl.gpio_dir = dir_eff[n];
		end
		pam_pin_cell u_cell (
			.clock(CLOCK),
			.rst(RST),
			.pin_in(PIN_IN[n]),
			.ctl(ctl),
			.pin_out(PIN_OUT[n]),
			.pin_oe_n(PIN_OE_N[n]),
			.level(level[n])
		);
	end

	// filtered pin levels toward the GPIO data register
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			GPIO_IN <= '0;
		end else begin
			GPIO_IN <= level;
		end
	end

	// serial inputs see the pin only while routed; idle values otherwise
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			SER1_RX <= 1'b1;
		end else begin
			SER1_RX <= alt_sel[14] ? level[14] : 1'b1;
		end
	end

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			SER1_CLK_IN <= 1'b0;
		end else begin
			SER1_CLK_IN <= alt_sel[13] ? level[13] : 1'b0;
		end
	end

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			SER0_CLK_IN <= 1'b0;
		end else begin
			SER0_CLK_IN <= alt_sel[12] ? level[12] : 1'b0;
		end
	end

endmodule

`default_nettype wire

// [test/pam_port_a_asserts.sv]
// checker for the port A pin-control block, bound to its top module
// assumes byte lanes 0 and 1 carry the two register bytes
`timescale 1ns/1ps
`default_nettype none
module pam_chk #(
	parameter int ADDR_W = 12
) (
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [ADDR_W-1:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [3:0] PSTRB,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic [15:0] PIN_OE_N,
	input wire logic SER1_CLK_DRIVE,
	input wire logic SER0_CLK_DRIVE
);
	import pam_pkg::*;
	logic [15:0] dir;
	logic [15:0] fn;
	logic [15:0] lane;
	logic wr;
	logic rd;
	assign wr = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;
	assign rd = PREADY && !PWRITE;
	assign lane = {{8{PSTRB[1]}}, {8{PSTRB[0]}}};
	// shadow copies of both registers, byte lane by byte lane
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST)
			dir <= DIR_RESET;
		else if (wr && PADDR == ADDR_W'(DIR_OFFSET))
			dir <= (PWDATA[15:0] & lane) | (dir & ~lane);
	end
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST)
			fn <= FUNC_RESET;
		else if (wr && PADDR == ADDR_W'(FUNC_OFFSET))
			fn <= ((PWDATA[15:0] & lane) | (fn & ~lane)) & FUNC_WRITE_MASK;
	end
	default clocking @(posedge CLOCK); endclocking
	default disable iff (RST);
	ready_after_setup_a: assert property (PSEL && !PENABLE |=> PREADY)
		else $error("no ready after setup");
	ready_pulse_a: assert property (PREADY |=> !PREADY)
		else $error("ready held");
	dir_read_a: assert property (rd && PADDR == ADDR_W'(DIR_OFFSET) |-> PRDATA == {16'h0000, dir})
		else $error("direction readback");
	func_read_a: assert property (rd && PADDR == ADDR_W'(FUNC_OFFSET) |-> PRDATA == {16'h0000, fn})
		else $error("function readback");
	gpio_dir_a: assert property (PIN_OE_N[11:0] == ~$past(dir[11:0]))
		else $error("pin drive vs direction");
	tx_route_a: assert property ($past(fn[14:12]) == FUNC_SERIAL |-> !PIN_OE_N[15])
		else $error("transmit pin not driven");
	rx_free_a: assert property ($past(fn[10:8]) == FUNC_SERIAL |-> PIN_OE_N[14])
		else $error("receive pin driven");
	clk1_drive_a: assert property ($past(fn[6:4]) == FUNC_SERIAL |-> PIN_OE_N[13] == !$past(SER1_CLK_DRIVE))
		else $error("serial1 clock drive");
	clk0_drive_a: assert property ($past(fn[2:0]) == FUNC_SERIAL |-> PIN_OE_N[12] == !$past(SER0_CLK_DRIVE))
		else $error("serial0 clock drive");
endmodule
bind pam_port_a pam_chk #(.ADDR_W(ADDR_W)) u_chk (.*);
`default_nettype wire

// [test/pam_pads.sv]
// pad model: a driven pad reads back its own output, a released one the outside level
// assumes ext is held by the bench as the outside device
`timescale 1ns/1ps
`default_nettype none
module pam_pads (
	input wire logic [15:0] pin_out,
	input wire logic [15:0] pin_oe_n,
	input wire logic [15:0] ext,
	output logic [15:0] pin_in
);
	assign pin_in = (pin_oe_n & ext) | (~pin_oe_n & pin_out);
endmodule
`default_nettype wire

// [test/tb_pam_port_a.sv]
// testbench for the port A pin-control block
// assumes a 200 MHz clock and the pad model beside the design
`timescale 1ns/1ps
`default_nettype none
module tb_pam_port_a;
	import pam_pkg::*;
	logic CLOCK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, err;
	logic SER1_TX, SER1_RX, SER1_CLK_OUT, SER1_CLK_DRIVE, SER1_CLK_IN;
	logic SER0_CLK_OUT, SER0_CLK_DRIVE, SER0_CLK_IN;
	logic [11:0] PADDR;
	logic [31:0] PWDATA, PRDATA, rd;
	logic [3:0] PSTRB;
	logic [15:0] PIN_IN, PIN_OUT, PIN_OE_N, GPIO_OUT, GPIO_IN, ext;
	int mismatches, checked, cycles;
	pam_port_a u_dut (.*);
	pam_pads u_pads (.pin_out(PIN_OUT), .pin_oe_n(PIN_OE_N), .ext(ext), .pin_in(PIN_IN));
	initial begin
		CLOCK = 1'b0;
		forever #2.5 CLOCK = ~CLOCK;
	end
	task report_and_stop;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge CLOCK) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			report_and_stop;
		end
	end
	task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s exp %h seen %h", name, exp, seen);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [15:0] d);
		@(posedge CLOCK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= {16'h0000, d};
		@(posedge CLOCK);
		PENABLE <= 1'b1;
		do @(posedge CLOCK); while (PREADY !== 1'b1);
		rd = PRDATA;
		err = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask
	task rdchk(input logic [11:0] a, input logic [15:0] exp);
		apb(1'b0, a, 16'h0000);
		chk("rdata", rd[15:0], exp);
	endtask
	initial begin
		{PSEL, PENABLE, PWRITE, SER1_TX, SER1_CLK_OUT, SER1_CLK_DRIVE} = 6'h00;
		{SER0_CLK_OUT, SER0_CLK_DRIVE, PADDR, PWDATA} = '0;
		{GPIO_OUT, ext} = 32'h00000000;
		PSTRB = 4'hf;
		RST = 1'b1;
		repeat (8) @(posedge CLOCK);
		RST <= 1'b0;
		rdchk(DIR_OFFSET, 16'h0000);
		rdchk(FUNC_OFFSET, 16'h0000);
		chk("oe", PIN_OE_N, 16'hffff);
		$display("test reset done");
		ext <= 16'h5a5a;
		GPIO_OUT <= 16'h0ff0;
		apb(1'b1, DIR_OFFSET, 16'h0f0f);
		rdchk(DIR_OFFSET, 16'h0f0f);
		repeat (8) @(posedge CLOCK);
		chk("oe", PIN_OE_N, 16'hf0f0);
		chk("level", GPIO_IN, 16'h5f50);
		$display("test direction done");
		{SER1_TX, SER0_CLK_OUT, SER0_CLK_DRIVE} <= 3'h7;
		ext <= 16'h2000;
		GPIO_OUT <= 16'h0000;
		apb(1'b1, DIR_OFFSET, 16'hffff);
		apb(1'b1, FUNC_OFFSET, 16'h6666);
		rdchk(FUNC_OFFSET, 16'h6666);
		repeat (8) @(posedge CLOCK);
		chk("oe", PIN_OE_N, 16'h6000);
		chk("level", GPIO_IN, 16'hb000);
		chk("rx", 16'(SER1_RX), 16'h0000);
		chk("clk1", 16'(SER1_CLK_IN), 16'h0001);
		chk("clk0", 16'(SER0_CLK_IN), 16'h0001);
		apb(1'b1, FUNC_OFFSET, 16'h0000);
		repeat (3) @(posedge CLOCK);
		chk("oe", PIN_OE_N, 16'h0000);
		$display("test function done");
		ext <= 16'h000f;
		PSTRB <= 4'h1;
		apb(1'b1, DIR_OFFSET, 16'h00f0);
		PSTRB <= 4'hf;
		rdchk(DIR_OFFSET, 16'hfff0);
		repeat (8) @(posedge CLOCK);
		rdchk(LEVEL_OFFSET, 16'h000f);
		apb(1'b1, LEVEL_OFFSET, 16'hffff);
		chk("slverr", 16'(err), 16'h0001);
		chk("oe", PIN_OE_N, 16'h000f);
		$display("test strobe done");
		apb(1'b0, 12'h00c, 16'h0000);
		chk("slverr", 16'(err), 16'h0001);
		$display("test unmapped done");
		report_and_stop;
	end
endmodule
`default_nettype wire
